// ==== hw/ptf_top.sv ====
// Per-port trace and filter decision for one switch ingress port.
// Assumes header descriptors and config come from same-clock switch logic.

`timescale 1ns/10ps

module ptf_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Global switch control
    input wire logic trace_global_en,
    input wire logic [ptf_pkg::PORT_W-1:0] trace_port_sel,
    input wire logic trace_only_mode,
    // Port operation control
    input wire logic [ptf_pkg::PORT_W-1:0] port_id,
    input wire logic port_trace_en,
    input wire logic [ptf_pkg::NVAL-1:0] val_trace_en,
    input wire logic [ptf_pkg::NVAL-1:0] val_filter_en,
    input wire logic port_write_en,
    // Comparison value and mask write
    input wire logic cfg_wr,
    input wire logic cfg_bcast,
    input wire logic [ptf_pkg::PORT_W-1:0] cfg_port,
    input wire logic cfg_mask,
    input wire logic [ptf_pkg::IDX_W-1:0] cfg_idx,
    input wire logic [ptf_pkg::WSEL_W-1:0] cfg_word,
    input wire logic [ptf_pkg::WORD_BITS-1:0] cfg_wdata,
    // Received packet head
    input wire logic hdr_valid,
    input wire logic [ptf_pkg::CMP_BITS-1:0] hdr_bits,
    input wire logic [ptf_pkg::LEN_W-1:0] hdr_len,
    input wire logic hdr_crc_err,
    input wire logic hdr_from_maint,
    input wire logic hdr_is_maint,
    input wire logic hdr_hop_zero,
    input wire logic hdr_no_route,
    input wire logic hdr_mcast,
    input wire logic [ptf_pkg::PORT_W-1:0] hdr_route_port,
    input wire logic [ptf_pkg::NPORTS-1:0] hdr_mcast_ports,
    // Trace output port buffer state
    input wire logic trace_room,
    // Forwarding decision
    output logic dec_valid,
    output logic [ptf_pkg::NPORTS-1:0] dec_ports,
    output logic dec_nack,
    output logic dec_drop,
    output logic dec_local,
    output logic dec_traced,
    output logic pw_req,
    // Counter read
    input wire logic cnt_rd,
    input wire logic cnt_filter,
    input wire logic [ptf_pkg::IDX_W-1:0] cnt_idx,
    output logic cnt_rvalid,
    output logic [ptf_pkg::WORD_BITS-1:0] cnt_rdata
);
    logic v1;
    logic phys1;
    logic from_maint1;
    logic is_maint1;
    logic hop_zero1;
    logic no_route1;
    logic mcast1;
    logic [ptf_pkg::PORT_W-1:0] route_port1;
    logic [ptf_pkg::NPORTS-1:0] mcast_ports1;
    logic [ptf_pkg::NVAL-1:0] hit;
    logic [ptf_pkg::NVAL-1:0] inc_trace;
    logic [ptf_pkg::NVAL-1:0] inc_filter;
    logic [ptf_pkg::NVAL-1:0] rd_trace;
    logic [ptf_pkg::NVAL-1:0] rd_filter;
    logic [ptf_pkg::WORD_BITS-1:0] trace_cnt [ptf_pkg::NVAL];
    logic [ptf_pkg::WORD_BITS-1:0] filter_cnt [ptf_pkg::NVAL];
    logic wr_here;
    logic trace_hit;
    logic filter_hit;
    logic next_nack;
    logic [ptf_pkg::NPORTS-1:0] trace_sel;
    logic [ptf_pkg::NPORTS-1:0] normal_ports;
    logic [ptf_pkg::NPORTS-1:0] next_ports;
    logic [ptf_pkg::NPORTS-1:0] trace_sel_q;

    // Broadcast write reaches every port at once
    assign wr_here = cfg_wr && (cfg_bcast || cfg_port == port_id);

    // Descriptor stage, aligned with the registered compare
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            v1 <= 1'b0;
            phys1 <= 1'b0;
            from_maint1 <= 1'b0;
            is_maint1 <= 1'b0;
            hop_zero1 <= 1'b0;
            no_route1 <= 1'b0;
            mcast1 <= 1'b0;
            route_port1 <= '0;
            mcast_ports1 <= ptf_pkg::PORTS_NONE;
        end else begin
            v1 <= hdr_valid;
            phys1 <= hdr_crc_err || hdr_len > ptf_pkg::MAX_PKT_BYTES;
            from_maint1 <= hdr_from_maint;
            is_maint1 <= hdr_is_maint;
            hop_zero1 <= hdr_hop_zero;
            no_route1 <= hdr_no_route;
            mcast1 <= hdr_mcast;
            route_port1 <= hdr_route_port;
            mcast_ports1 <= hdr_mcast_ports;
        end
    end

    // One compare slot per comparison value
    genvar gi;
    generate
        for (gi = 0; gi < ptf_pkg::NVAL; gi++) begin : g_val
            assign rd_trace[gi] = cnt_rd && !cnt_filter && cnt_idx == 2'(gi);
            assign rd_filter[gi] = cnt_rd && cnt_filter && cnt_idx == 2'(gi);
            ptf_match u_match (
                .clk(clk),
                .rst_n(rst_n),
                .wr_en(wr_here && cfg_idx == 2'(gi)),
                .wr_mask(cfg_mask),
                .wr_word(cfg_word),
                .wr_data(cfg_wdata),
                .hdr_bits(hdr_bits),
                .hit(hit[gi]),
                .inc_trace(inc_trace[gi]),
                .inc_filter(inc_filter[gi]),
                .rd_trace(rd_trace[gi]),
                .rd_filter(rd_filter[gi]),
                .trace_cnt(trace_cnt[gi]),
                .filter_cnt(filter_cnt[gi])
            );
        end
    endgenerate

    // Routing decision from the packet head, the trace and filter settings and trace_room
    always_comb begin
        trace_sel = trace_global_en ? (ptf_pkg::PORT_ONE << trace_port_sel) : ptf_pkg::PORTS_NONE;
        // Logical errors do not block tracing; physical ones do
        trace_hit = trace_global_en && port_trace_en && |(hit & val_trace_en) && !phys1;
        filter_hit = |(hit & val_filter_en);
        if (no_route1) begin
            normal_ports = ptf_pkg::PORTS_NONE;
        end else if (mcast1) begin
            normal_ports = mcast_ports1;
        end else begin
            normal_ports = ptf_pkg::PORT_ONE << route_port1;
        end
        if (trace_global_en && trace_only_mode && !trace_hit && !from_maint1) begin
            normal_ports = normal_ports & ~trace_sel;
        end
        if (trace_only_mode && |val_filter_en && !filter_hit && !trace_hit && !from_maint1) begin
            normal_ports = ptf_pkg::PORTS_NONE;
        end
        if (filter_hit) begin
            normal_ports = ptf_pkg::PORTS_NONE;
        end
        next_nack = trace_hit && !trace_room;
        if (next_nack) begin
            next_ports = ptf_pkg::PORTS_NONE;
        end else if (trace_hit) begin
            next_ports = normal_ports | trace_sel;
        end else begin
            next_ports = normal_ports;
        end
    end

    // A matching value counts once per accepted packet, only in the counter it is enabled for; trace counts also need trace_hit
    always_comb begin
        for (int i = 0; i < ptf_pkg::NVAL; i++) begin
            inc_trace[i] = v1 && trace_hit && !next_nack && hit[i] && val_trace_en[i];
            inc_filter[i] = v1 && filter_hit && !next_nack && hit[i] && val_filter_en[i];
        end
    end

    // Decision register; the output port queues it like any packet
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dec_valid <= 1'b0;
            dec_ports <= ptf_pkg::PORTS_NONE;
            dec_nack <= 1'b0;
            dec_drop <= 1'b0;
            dec_local <= 1'b0;
            dec_traced <= 1'b0;
            trace_sel_q <= ptf_pkg::PORTS_NONE;
        end else begin
            dec_valid <= v1;
            dec_ports <= v1 ? next_ports : ptf_pkg::PORTS_NONE;
            dec_nack <= v1 && next_nack;
            dec_drop <= v1 && !next_nack && next_ports == ptf_pkg::PORTS_NONE;
            dec_local <= v1 && is_maint1 && hop_zero1 && !filter_hit && !phys1 && !next_nack;
            dec_traced <= v1 && trace_hit && !next_nack;
            trace_sel_q <= trace_sel;
        end
    end

    // Port-write request on a traced packet
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pw_req <= 1'b0;
        end else begin
            pw_req <= v1 && trace_hit && !next_nack && port_write_en;
        end
    end

    // Counter read returns the value before the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_rvalid <= 1'b0;
            cnt_rdata <= ptf_pkg::CNT_ZERO;
        end else begin
            cnt_rvalid <= cnt_rd;
            if (cnt_rd) begin
                cnt_rdata <= cnt_filter ? filter_cnt[cnt_idx] : trace_cnt[cnt_idx];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_head_in;
        hdr_valid;
    endsequence

    sequence s_decided;
        ##2 dec_valid;
    endsequence

    property p_latency;
        s_head_in |-> s_decided;
    endproperty
    a_latency: assert property (p_latency) else $error("decision not two cycles after head");

    property p_nack_nowhere;
        dec_nack |-> dec_valid && dec_ports == ptf_pkg::PORTS_NONE && !dec_traced;
    endproperty
    a_nack_nowhere: assert property (p_nack_nowhere) else $error("nacked packet still forwarded");

    property p_congest_nack;
        v1 && trace_hit && !trace_room |=> dec_nack;
    endproperty
    a_congest_nack: assert property (p_congest_nack) else $error("congested trace port not nacked");

    property p_phys_untraced;
        v1 && phys1 |=> !dec_traced && (dec_ports & trace_sel_q & ~$past(normal_ports)) == ptf_pkg::PORTS_NONE;
    endproperty
    a_phys_untraced: assert property (p_phys_untraced) else $error("errored packet traced");

    property p_trace_copy;
        dec_traced |-> (dec_ports & trace_sel_q) != ptf_pkg::PORTS_NONE;
    endproperty
    a_trace_copy: assert property (p_trace_copy) else $error("traced packet missed trace port");

    property p_trace_only;
        v1 && trace_global_en && trace_only_mode && !trace_hit && !from_maint1 |=>
            (dec_ports & trace_sel_q) == ptf_pkg::PORTS_NONE;
    endproperty
    a_trace_only: assert property (p_trace_only) else $error("unmatched packet sent to trace port");

    property p_filter_drop;
        v1 && filter_hit && !trace_hit |=> dec_drop && dec_ports == ptf_pkg::PORTS_NONE;
    endproperty
    a_filter_drop: assert property (p_filter_drop) else $error("filtered packet forwarded");

    property p_filter_local;
        v1 && filter_hit |=> !dec_local;
    endproperty
    a_filter_local: assert property (p_filter_local) else $error("filtered maintenance packet accepted");

    property p_pw;
        pw_req |-> dec_traced && $past(port_write_en);
    endproperty
    a_pw: assert property (p_pw) else $error("port-write without enabled trace match");

    property p_read_data;
        cnt_rd && !cnt_filter |=> cnt_rvalid && cnt_rdata == $past(trace_cnt[cnt_idx]);
    endproperty
    a_read_data: assert property (p_read_data) else $error("counter read returned wrong value");

    sequence s_no_head;
        !hdr_valid;
    endsequence

    sequence s_quiet;
        ##2 !dec_valid;
    endsequence

    property p_quiet;
        s_no_head |-> s_quiet;
    endproperty
    a_quiet: assert property (p_quiet) else $error("decision without a head");

    property p_idle_outputs;
        !dec_valid |-> dec_ports == ptf_pkg::PORTS_NONE && !dec_nack && !dec_drop &&
            !dec_local && !dec_traced && !pw_req;
    endproperty
    a_idle_outputs: assert property (p_idle_outputs) else $error("decision outputs set while idle");

    property p_drop_alone;
        dec_drop |-> dec_valid && !dec_nack && dec_ports == ptf_pkg::PORTS_NONE;
    endproperty
    a_drop_alone: assert property (p_drop_alone) else $error("dropped packet has a destination");

    property p_filter_trace;
        v1 && filter_hit && trace_hit && trace_room |=> dec_traced && dec_ports == trace_sel_q;
    endproperty
    a_filter_trace: assert property (p_filter_trace) else $error("filtered and traced packet misrouted");

    property p_filter_untraced;
        v1 && filter_hit && !(|(hit & val_trace_en)) |=> !dec_traced && dec_ports == ptf_pkg::PORTS_NONE;
    endproperty
    a_filter_untraced: assert property (p_filter_untraced) else $error("filter-only packet traced");

    property p_default_keep;
        v1 && !trace_only_mode && !filter_hit && !no_route1 && !mcast1 && !next_nack |=> dec_ports[$past(route_port1)];
    endproperty
    a_default_keep: assert property (p_default_keep) else $error("default mode lost routed port");

    property p_no_route_trace;
        v1 && no_route1 && trace_hit && trace_room |=> dec_ports == trace_sel_q;
    endproperty
    a_no_route_trace: assert property (p_no_route_trace) else $error("unrouted traced packet lost");

    property p_mcast_only;
        v1 && trace_global_en && trace_only_mode && mcast1 && !no_route1 && !trace_hit && !from_maint1 &&
            val_filter_en == '0 |=> dec_ports == ($past(mcast_ports1) & ~trace_sel_q);
    endproperty
    a_mcast_only: assert property (p_mcast_only) else $error("multicast members wrong in trace-only");

    property p_maint_trace;
        v1 && trace_only_mode && from_maint1 && !filter_hit && !no_route1 && !mcast1 && !next_nack |=>
            dec_ports[$past(route_port1)];
    endproperty
    a_maint_trace: assert property (p_maint_trace) else $error("maintenance handler packet removed");

    property p_nack_quiet;
        v1 && next_nack |=> !pw_req && !dec_local && !dec_drop;
    endproperty
    a_nack_quiet: assert property (p_nack_quiet) else $error("nacked packet had side effects");

    property p_pw_fire;
        v1 && trace_hit && !next_nack && port_write_en |=> pw_req;
    endproperty
    a_pw_fire: assert property (p_pw_fire) else $error("port-write request missing");

    property p_filter_miss_only;
        v1 && trace_only_mode && val_filter_en != '0 && !filter_hit && !trace_hit && !from_maint1 |=>
            dec_drop && dec_ports == ptf_pkg::PORTS_NONE;
    endproperty
    a_filter_miss_only: assert property (p_filter_miss_only) else $error("filter miss routed in trace-only");

    property p_rvalid;
        cnt_rvalid == $past(cnt_rd);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");

    property p_filter_read;
        cnt_rd && cnt_filter |=> cnt_rvalid && cnt_rdata == $past(filter_cnt[cnt_idx]);
    endproperty
    a_filter_read: assert property (p_filter_read) else $error("filter counter read wrong");
endmodule

// ==== hw/ptf_match.sv ====
// Packet trace and filter package, plus one comparison value slot.
// Assumes a single core clock and synchronous active-low reset.

package ptf_pkg;
    localparam int NVAL = 4;
    localparam int CMP_BITS = 160;
    localparam int WORD_BITS = 32;
    localparam int NWORDS = 5;
    localparam int NPORTS = 16;
    localparam int PORT_W = 4;
    localparam int IDX_W = 2;
    localparam int WSEL_W = 3;
    localparam int LEN_W = 9;
    localparam logic [LEN_W-1:0] MAX_PKT_BYTES = 9'h114;
    localparam logic [WORD_BITS-1:0] CNT_MAX = 32'hFFFFFFFF;
    localparam logic [WORD_BITS-1:0] CNT_ONE = 32'h00000001;
    localparam logic [WORD_BITS-1:0] CNT_ZERO = 32'h00000000;
    localparam logic [CMP_BITS-1:0] CMP_ZERO = '0;
    localparam logic [NPORTS-1:0] PORTS_NONE = 16'h0000;
    localparam logic [NPORTS-1:0] PORT_ONE = 16'h0001;
endpackage

`timescale 1ns/10ps

module ptf_match (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Value and mask write
    input wire logic wr_en,
    input wire logic wr_mask,
    input wire logic [ptf_pkg::WSEL_W-1:0] wr_word,
    input wire logic [ptf_pkg::WORD_BITS-1:0] wr_data,
    // Packet head
    input wire logic [ptf_pkg::CMP_BITS-1:0] hdr_bits,
    output logic hit,
    // Counters
    input wire logic inc_trace,
    input wire logic inc_filter,
    input wire logic rd_trace,
    input wire logic rd_filter,
    output logic [ptf_pkg::WORD_BITS-1:0] trace_cnt,
    output logic [ptf_pkg::WORD_BITS-1:0] filter_cnt
);
    logic [ptf_pkg::CMP_BITS-1:0] value;
    logic [ptf_pkg::CMP_BITS-1:0] mask;

    // Live update of one 32-bit word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value <= ptf_pkg::CMP_ZERO;
            mask <= ptf_pkg::CMP_ZERO;
        end else if (wr_en) begin
            for (int w = 0; w < ptf_pkg::NWORDS; w++) begin
                if (wr_word == 3'(w)) begin
                    if (wr_mask) begin
                        mask[w*ptf_pkg::WORD_BITS +: ptf_pkg::WORD_BITS] <= wr_data;
                    end else begin
                        value[w*ptf_pkg::WORD_BITS +: ptf_pkg::WORD_BITS] <= wr_data;
                    end
                end
            end
        end
    end

    // Zero mask bit is don't care
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit <= 1'b0;
        end else begin
            hit <= ((hdr_bits ^ value) & mask) == ptf_pkg::CMP_ZERO;
        end
    end

    // Saturating, clear on read; an increment in the read cycle leaves the count at one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trace_cnt <= ptf_pkg::CNT_ZERO;
        end else if (inc_trace) begin
            trace_cnt <= rd_trace ? ptf_pkg::CNT_ONE :
                (trace_cnt == ptf_pkg::CNT_MAX ? trace_cnt : trace_cnt + ptf_pkg::CNT_ONE);
        end else if (rd_trace) begin
            trace_cnt <= ptf_pkg::CNT_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filter_cnt <= ptf_pkg::CNT_ZERO;
        end else if (inc_filter) begin
            filter_cnt <= rd_filter ? ptf_pkg::CNT_ONE :
                (filter_cnt == ptf_pkg::CNT_MAX ? filter_cnt : filter_cnt + ptf_pkg::CNT_ONE);
        end else if (rd_filter) begin
            filter_cnt <= ptf_pkg::CNT_ZERO;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_trace_count;
        inc_trace && !rd_trace && trace_cnt != ptf_pkg::CNT_MAX |=> trace_cnt == $past(trace_cnt) + ptf_pkg::CNT_ONE;
    endproperty
    a_trace_count: assert property (p_trace_count) else $error("trace counter missed an increment");

    property p_saturate;
        inc_filter && !rd_filter && filter_cnt == ptf_pkg::CNT_MAX |=> filter_cnt == ptf_pkg::CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("filter counter wrapped");

    property p_read_clear;
        rd_trace && !inc_trace |=> trace_cnt == ptf_pkg::CNT_ZERO;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("trace counter not cleared by read");
endmodule

// ==== test/ptf_far_model.sv ====
// Far-side model: trace output port buffer state and trace copy count.
// Assumes the same core clock and synchronous reset as the decision block.
`timescale 1ns/10ps

module ptf_far_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Congestion command from the bench
    input wire logic congest,
    // Decision from the block
    input wire logic dec_valid,
    input wire logic [ptf_pkg::NPORTS-1:0] dec_ports,
    input wire logic [ptf_pkg::PORT_W-1:0] trace_port_sel,
    // Buffer state and accepted copies
    output logic trace_room,
    output int copies
);
    // Room follows the congestion command one cycle later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trace_room <= 1'b1;
        end else begin
            trace_room <= !congest;
        end
    end

    // Trace copies are queued like any other delivery
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            copies <= 0;
        end else if (dec_valid && dec_ports[trace_port_sel]) begin
            copies <= copies + 1;
        end
    end
endmodule

// ==== test/tb.sv ====
// Testbench for the per-port trace and filter decision block.
// Assumes the far-side model and the design package are compiled first.
`timescale 1ns/10ps

module tb;
    localparam logic [159:0] HIT = 160'h5A5AC3C3;
    localparam logic [159:0] MISS = 160'h1;
    localparam logic [159:0] MISS1 = 160'h100000001;
    localparam logic [15:0] P3 = 16'h0008;
    localparam logic [15:0] P5 = 16'h0020;
    localparam logic [5:0] F0 = 6'h00;
    localparam logic [5:0] FCRC = 6'h20;
    localparam logic [5:0] FFM = 6'h10;
    localparam logic [5:0] FMH = 6'h0E;
    localparam logic [5:0] FNR = 6'h02;
    localparam logic [5:0] FMC = 6'h01;

    logic clk = 1'b0, rst_n = 1'b0, trace_global_en = 1'b0, trace_only_mode = 1'b0;
    logic [3:0] trace_port_sel = 4'h5, port_id = 4'h2, cfg_port = 4'h0, hdr_route_port = 4'h3;
    logic port_trace_en = 1'b0, port_write_en = 1'b0, cfg_wr = 1'b0, cfg_bcast = 1'b0, cfg_mask = 1'b0;
    logic [3:0] val_trace_en = 4'h0, val_filter_en = 4'h0;
    logic [1:0] cfg_idx = 2'h0, cnt_idx = 2'h0;
    logic [2:0] cfg_word = 3'h0;
    logic [31:0] cfg_wdata = 32'h00000000;
    logic hdr_valid = 1'b0, hdr_crc_err = 1'b0, hdr_from_maint = 1'b0, hdr_is_maint = 1'b0;
    logic hdr_hop_zero = 1'b0, hdr_no_route = 1'b0, hdr_mcast = 1'b0, cnt_rd = 1'b0, cnt_filter = 1'b0;
    logic [159:0] hdr_bits = 160'h0;
    logic [8:0] hdr_len = 9'h040;
    logic [15:0] hdr_mcast_ports = 16'h0000;
    logic congest = 1'b0, trace_room, dec_valid, dec_nack, dec_drop, dec_local, dec_traced, pw_req, cnt_rvalid;
    logic [15:0] dec_ports;
    logic [31:0] cnt_rdata;
    int copies, exp_copies = 0, fails = 0, cmp_count = 0;

    always #2.5 clk = ~clk;

    ptf_top ptf_top_inst (
        .clk, .rst_n, .trace_global_en, .trace_port_sel, .trace_only_mode, .port_id, .port_trace_en,
        .val_trace_en, .val_filter_en, .port_write_en, .cfg_wr, .cfg_bcast, .cfg_port, .cfg_mask,
        .cfg_idx, .cfg_word, .cfg_wdata, .hdr_valid, .hdr_bits, .hdr_len, .hdr_crc_err,
        .hdr_from_maint, .hdr_is_maint, .hdr_hop_zero, .hdr_no_route, .hdr_mcast, .hdr_route_port,
        .hdr_mcast_ports, .trace_room, .dec_valid, .dec_ports, .dec_nack, .dec_drop, .dec_local,
        .dec_traced, .pw_req, .cnt_rd, .cnt_filter, .cnt_idx, .cnt_rvalid, .cnt_rdata
    );

    ptf_far_model ptf_far_model_inst (
        .clk, .rst_n, .congest, .dec_valid, .dec_ports, .trace_port_sel, .trace_room, .copies
    );

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic set(input logic md, input logic [3:0] te, input logic [3:0] fe, input logic pw);
        @(posedge clk);
        trace_only_mode <= md;
        val_trace_en <= te;
        val_filter_en <= fe;
        port_write_en <= pw;
    endtask

    task automatic wr(input logic bc, input logic [3:0] p, input logic m, input logic [1:0] i,
        input logic [2:0] w, input logic [31:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_bcast <= bc;
        cfg_port <= p;
        cfg_mask <= m;
        cfg_idx <= i;
        cfg_word <= w;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask

    task automatic rd(input logic f, input logic [1:0] i, input logic [31:0] xv, input logic ck = 1'b1);
        @(posedge clk);
        cnt_rd <= 1'b1;
        cnt_filter <= f;
        cnt_idx <= i;
        @(posedge clk);
        cnt_rd <= 1'b0;
        #1;
        if (ck) chk(cnt_rvalid === 1'b1 && cnt_rdata === xv, "counter read");
    endtask

    task automatic pkt(input logic [159:0] bits, input logic [5:0] fl, input logic [3:0] rp,
        input logic [15:0] mc, input logic [15:0] xp, input logic xt, input logic xn = 1'b0,
        input logic xl = 1'b0, input logic [8:0] len = 9'h040);
        @(posedge clk);
        hdr_valid <= 1'b1;
        hdr_bits <= bits;
        {hdr_crc_err, hdr_from_maint, hdr_is_maint, hdr_hop_zero, hdr_no_route, hdr_mcast} <= fl;
        hdr_route_port <= rp;
        hdr_mcast_ports <= mc;
        hdr_len <= len;
        @(posedge clk);
        hdr_valid <= 1'b0;
        @(posedge clk);
        #1;
        if (xp[trace_port_sel]) exp_copies++;
        chk(dec_valid === 1'b1 && dec_ports === xp && dec_nack === xn, "decision ports or nack");
        chk(dec_local === xl, "local accept");
        if (!xn) chk(dec_traced === xt && pw_req === (xt & port_write_en), "trace copy or port-write");
        if (!fl[3]) chk(dec_drop === (xp == 16'h0000 && !xn), "drop flag");
    endtask

    task automatic t_reset();
        @(posedge clk);
        #1;
        chk(dec_valid === 1'b0 && cnt_rvalid === 1'b0 && pw_req === 1'b0, "idle after reset");
        rd(1'b0, 2'h0, 32'h00000000);
        rd(1'b1, 2'h3, 32'h00000000);
        wr(1'b1, 4'hF, 1'b0, 2'h0, 3'h0, 32'h5A5AC3C3);
        wr(1'b1, 4'hF, 1'b1, 2'h0, 3'h0, 32'hFFFFFFFF);
        wr(1'b0, 4'h2, 1'b1, 2'h1, 3'h1, 32'hFFFFFFFF);
        wr(1'b0, 4'h9, 1'b0, 2'h1, 3'h1, 32'h00000001);
        wr(1'b1, 4'hF, 1'b1, 2'h0, 3'h5, 32'h00000000);
        $display("test reset and config done");
    endtask

    task automatic t_default();
        set(1'b0, 4'h1, 4'h0, 1'b1);
        pkt(HIT, F0, 4'h3, 16'h0000, P3 | P5, 1'b1);
        pkt(MISS, F0, 4'h5, 16'h0000, P5, 1'b0);
        pkt(HIT, FNR, 4'h3, 16'h0000, P5, 1'b1);
        @(posedge clk);
        trace_global_en <= 1'b0;
        pkt(HIT, F0, 4'h3, 16'h0000, P3, 1'b0);
        @(posedge clk);
        trace_port_sel <= 4'h7;
        @(posedge clk);
        trace_global_en <= 1'b1;
        pkt(HIT, F0, 4'h3, 16'h0000, P3 | 16'h0080, 1'b1);
        @(posedge clk);
        trace_global_en <= 1'b0;
        @(posedge clk);
        trace_port_sel <= 4'h5;
        trace_global_en <= 1'b1;
        set(1'b0, 4'h2, 4'h0, 1'b0);
        pkt(MISS1, F0, 4'h3, 16'h0000, P3, 1'b0);
        pkt(MISS, F0, 4'h3, 16'h0000, P3 | P5, 1'b1);
        $display("test default mode done");
    endtask

    task automatic t_only();
        set(1'b1, 4'h1, 4'h0, 1'b1);
        pkt(MISS, F0, 4'h5, 16'h0000, 16'h0000, 1'b0);
        pkt(MISS, FMC, 4'h3, 16'h00A8, 16'h0088, 1'b0);
        pkt(MISS, FFM, 4'h5, 16'h0000, P5, 1'b0);
        pkt(HIT, FMC, 4'h3, 16'h00A8, 16'h00A8, 1'b1);
        set(1'b0, 4'h1, 4'h0, 1'b1);
        pkt(HIT, FCRC, 4'h3, 16'h0000, P3, 1'b0);
        pkt(HIT, F0, 4'h3, 16'h0000, P3, 1'b0, 1'b0, 1'b0, 9'h115);
        pkt(HIT, F0, 4'h3, 16'h0000, P3 | P5, 1'b1, 1'b0, 1'b0, 9'h114);
        @(posedge clk);
        congest <= 1'b1;
        pkt(HIT, F0, 4'h3, 16'h0000, 16'h0000, 1'b0, 1'b1);
        pkt(MISS, F0, 4'h3, 16'h0000, P3, 1'b0);
        @(posedge clk);
        congest <= 1'b0;
        $display("test trace-only, errors and congestion done");
    endtask

    task automatic t_filter();
        set(1'b0, 4'h0, 4'h1, 1'b1);
        pkt(HIT, F0, 4'h3, 16'h0000, 16'h0000, 1'b0);
        pkt(MISS, F0, 4'h3, 16'h0000, P3, 1'b0);
        pkt(HIT, FMH, 4'h3, 16'h0000, 16'h0000, 1'b0);
        pkt(MISS, FMH, 4'h3, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1);
        set(1'b0, 4'h1, 4'h1, 1'b1);
        pkt(HIT, F0, 4'h3, 16'h0000, P5, 1'b1);
        set(1'b1, 4'h0, 4'h1, 1'b1);
        pkt(MISS, F0, 4'h3, 16'h0000, 16'h0000, 1'b0);
        set(1'b0, 4'h3, 4'h0, 1'b0);
        rd(1'b0, 2'h0, 32'h00000000, 1'b0);
        rd(1'b0, 2'h1, 32'h00000000, 1'b0);
        pkt(HIT, F0, 4'h3, 16'h0000, P3 | P5, 1'b1);
        pkt(HIT, F0, 4'h3, 16'h0000, P3 | P5, 1'b1);
        pkt(MISS1, F0, 4'h3, 16'h0000, P3, 1'b0);
        rd(1'b0, 2'h0, 32'h00000002);
        rd(1'b0, 2'h1, 32'h00000002);
        rd(1'b0, 2'h0, 32'h00000000);
        set(1'b0, 4'h0, 4'h1, 1'b0);
        rd(1'b1, 2'h0, 32'h00000000, 1'b0);
        pkt(HIT, F0, 4'h3, 16'h0000, 16'h0000, 1'b0);
        rd(1'b1, 2'h0, 32'h00000001);
        rd(1'b1, 2'h1, 32'h00000000);
        $display("test filter and counters done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        trace_global_en <= 1'b1;
        port_trace_en <= 1'b1;
        t_reset();
        t_default();
        t_only();
        t_filter();
        chk(copies === exp_copies, "trace copy count");
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
